// ==== hw/mctp_map.vh ====
/*
 * Register map, field positions, reset values and codes of the four-channel
 * compare timer. Assumes a 32-bit classic Wishbone slave with byte addresses.
 */
`ifndef MCTP_MAP_VH
`define MCTP_MAP_VH

// Byte offsets; channel n block sits at n * 0x40 plus the offset (address bits 7:6 pick the channel)
`define MCTP_RUN_OFF      8'h00
`define MCTP_CTL_OFF      6'h10
`define MCTP_MODE_OFF     6'h14
`define MCTP_IOC_OFF      6'h18
`define MCTP_IER_OFF      6'h1C
`define MCTP_SR_OFF       6'h20
`define MCTP_CNT_OFF      6'h24
`define MCTP_GRA_OFF      6'h28
`define MCTP_GRB_OFF      6'h2C
`define MCTP_GRC_OFF      6'h30
`define MCTP_GRD_OFF      6'h34

// Writable-bit masks; every other bit is reserved and reads zero
`define MCTP_CTL_MASK     16'h00FF
`define MCTP_MODE_MASK    16'h0077
`define MCTP_IOC_MASK     16'h0007
`define MCTP_IER_MASK     16'h001F
`define MCTP_RUN_MASK     16'h000F

// Reset values and the counter top value
`define MCTP_ZERO16       16'h0000
`define MCTP_GR_RST       16'hFFFF
`define MCTP_CNT_MAX      16'hFFFF

// Control register fields
`define MCTP_PSC_HI       2
`define MCTP_CLR_HI       7
`define MCTP_CLR_LO       5
// Mode register fields
`define MCTP_MD_HI        2
`define MCTP_BFA_BIT      4
`define MCTP_BFB_BIT      5
`define MCTP_BUFFER_WRITE_TIMING_BIT     6
// Pin control: bit 2 is the initial level, bits 1:0 the match action
`define MCTP_IOC_INIT     2

// Flag / enable bit positions
`define MCTP_F_A          0
`define MCTP_F_B          1
`define MCTP_F_C          2
`define MCTP_F_D          3
`define MCTP_F_OVF        4

// Codes
`define MCTP_MD_PWM       3'b010
`define MCTP_CLR_A        3'b001
`define MCTP_CLR_B        3'b010
`define MCTP_CLR_C        3'b101
`define MCTP_CLR_D        3'b110
`define MCTP_ACT_HOLD     2'b00
`define MCTP_ACT_LOW      2'b01
`define MCTP_ACT_HIGH     2'b10
`define MCTP_ACT_TGL      2'b11
`define MCTP_PSC_DIV1     2'b00
`define MCTP_PSC_DIV4     2'b01
`define MCTP_PSC_DIV16    2'b10
`define MCTP_PSC_DIV64    2'b11
`define MCTP_DIV4_M       6'h03
`define MCTP_DIV16_M      6'h0F
`define MCTP_DIV64_M      6'h3F

`endif

// ==== hw/mctp_timer.v ====
/*
 * Four-channel 16-bit compare timer with PWM, buffered compare registers,
 * per-channel output pin and per-channel interrupt request.
 * Assumes one 250 MHz clock, synchronous active-high reset and a classic
 * Wishbone master that holds each request until it sees ack.
 */
`timescale 1ns/10ps
`include "mctp_map.vh"

// Behaviour
// - Prescale code 011 divides by 64; top bit prohibited
// - Buffer timing: reload on match or clear
// - Buffer timing ignored without buffering enabled
// - Buffer enable B: D reloads B
// - Buffer enable A: C reloads A
// - Mode 000 normal, 010 PWM, rest prohibited
// - Reserved bits read zero, ignore writes
// - Codes 0xx: initial 0, then 0/1/toggle
// - Codes 1xx: initial 1, then 0/1/toggle
// - Enable bit 4 gates overflow request
// - Enable bits 3..0 gate compare D..A
// - Overflow flag set on wrap to zero
// - Compare flags set on counter equal register
// - Flag clears by writing 0 after reading 1
// - One 16-bit up-counter per channel, resets zero
// - Four general registers per channel, reset ones
// - Common run register, one bit per channel
// - Run bit 0 stops, 1 counts
module mctp_timer (
    input  wire        mclk,
    input  wire        srst,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire        wb_ack_o,
    output wire [3:0]  channel_output_pin,
    output wire [3:0]  irq_req
);

    // Bus slave and common state
    reg         ack_q;              // Registered acknowledge
    reg  [15:0] dat_q;              // Registered read data
    reg  [15:0] rd_d;               // Read mux result
    reg  [15:0] run_q;              // Common channel run register
    reg  [5:0]  psc_q;              // Shared free-running prescaler
    reg  [3:0]  irq_q;              // Registered interrupt requests

    // Per-channel registers
    reg  [15:0] ctl_q  [0:3];       // Prescale, edge, clear select
    reg  [15:0] mode_q [0:3];       // Channel mode register
    reg  [15:0] ioc_q  [0:3];       // Pin output control register
    reg  [15:0] ier_q  [0:3];       // Interrupt enable register
    reg  [4:0]  flg_q  [0:3];       // Event flags
    reg  [4:0]  arm_q  [0:3];       // Flags seen as 1 by a status read
    reg  [15:0] cnt_q  [0:3];       // Up-counter
    reg  [15:0] gra_q  [0:3];       // General register A
    reg  [15:0] grb_q  [0:3];       // General register B
    reg  [15:0] grc_q  [0:3];       // General register C
    reg  [15:0] grd_q  [0:3];       // General register D
    reg  [3:0]  pin_q;              // Output pin levels

    // Decode: a request is taken at the edge where ack is already high
    wire        req    = wb_cyc_i & wb_stb_i;
    wire        acc    = req & ack_q;
    wire        wr_acc = acc & wb_we_i;
    wire        rd_acc = acc & ~wb_we_i;
    wire [1:0]  ach    = wb_adr_i[7:6] - 2'd0;
    wire [5:0]  aoff   = wb_adr_i[5:0];
    wire        in_ch  = (aoff >= `MCTP_CTL_OFF) && (aoff <= `MCTP_GRD_OFF);

    assign wb_ack_o           = ack_q;
    assign wb_dat_o           = {16'h0000, dat_q};
    assign channel_output_pin = pin_q;
    assign irq_req            = irq_q;

    // Byte-lane merge for a 16-bit register in the low half-word
    function [15:0] mctp_merge;
        input [15:0] old;
        input [15:0] nw;
        input [1:0]  sel;
        begin
            mctp_merge = {sel[1] ? nw[15:8] : old[15:8],
                          sel[0] ? nw[7:0]  : old[7:0]};
        end
    endfunction

    // Ack and read data: one wait state, ack drops the cycle after
    always @(posedge mclk) begin
        if (srst) begin
            ack_q <= 1'b0;
            dat_q <= `MCTP_ZERO16;
        end else begin
            ack_q <= req & ~ack_q;
            dat_q <= rd_d;
        end
    end

    // Read mux; unmapped offsets answer zero
    always @* begin
        rd_d = `MCTP_ZERO16;
        if (wb_adr_i == `MCTP_RUN_OFF) begin
            rd_d = run_q;
        end else if (in_ch) begin
            case (aoff)
                `MCTP_CTL_OFF:  rd_d = ctl_q[ach];
                `MCTP_MODE_OFF: rd_d = mode_q[ach];
                `MCTP_IOC_OFF:  rd_d = ioc_q[ach];
                `MCTP_IER_OFF:  rd_d = ier_q[ach];
                `MCTP_SR_OFF:   rd_d = {11'h000, flg_q[ach]};
                `MCTP_CNT_OFF:  rd_d = cnt_q[ach];
                `MCTP_GRA_OFF:  rd_d = gra_q[ach];
                `MCTP_GRB_OFF:  rd_d = grb_q[ach];
                `MCTP_GRC_OFF:  rd_d = grc_q[ach];
                `MCTP_GRD_OFF:  rd_d = grd_q[ach];
                default:        rd_d = `MCTP_ZERO16;
            endcase
        end
    end

    // Run register and shared prescaler
    always @(posedge mclk) begin
        if (srst) begin
            run_q <= `MCTP_ZERO16;
            psc_q <= 6'h00;
        end else begin
            psc_q <= psc_q + 6'h01;
            if (wr_acc && wb_adr_i == `MCTP_RUN_OFF) begin
                // Only the four run bits store; upper bits stay zero
                run_q <= mctp_merge(run_q, wb_dat_i[15:0], wb_sel_i[1:0])
                         & `MCTP_RUN_MASK;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gch
            // Channel write strobes
            wire        wsel   = wr_acc && in_ch && (ach == g);
            wire [15:0] wd     = wb_dat_i[15:0];
            wire [1:0]  ws     = wb_sel_i[1:0];
            wire        sr_rd  = rd_acc && in_ch && (ach == g) && (aoff == `MCTP_SR_OFF);
            wire        sr_wr  = wsel && (aoff == `MCTP_SR_OFF) && ws[0];

            // Count tick from the prescaler; codes 1xx never tick
            reg         div_hit;
            always @* begin
                case (ctl_q[g][1:0])
                    `MCTP_PSC_DIV1:  div_hit = 1'b1;
                    `MCTP_PSC_DIV4:  div_hit = (psc_q[1:0] == `MCTP_DIV4_M);
                    `MCTP_PSC_DIV16: div_hit = (psc_q[3:0] == `MCTP_DIV16_M);
                    `MCTP_PSC_DIV64: div_hit = (psc_q == `MCTP_DIV64_M);
                    default:         div_hit = 1'b0;
                endcase
            end
            wire tick = run_q[g] & div_hit & ~ctl_q[g][`MCTP_PSC_HI];

            // Compare matches, only on a counting edge
            wire m_a = tick & (cnt_q[g] == gra_q[g]);
            wire m_b = tick & (cnt_q[g] == grb_q[g]);
            wire m_c = tick & (cnt_q[g] == grc_q[g]);
            wire m_d = tick & (cnt_q[g] == grd_q[g]);
            wire [2:0] csel = ctl_q[g][`MCTP_CLR_HI:`MCTP_CLR_LO];
            wire clr = (csel == `MCTP_CLR_A && m_a) || (csel == `MCTP_CLR_B && m_b)
                     || (csel == `MCTP_CLR_C && m_c) || (csel == `MCTP_CLR_D && m_d);
            wire ovf = tick & ~clr & (cnt_q[g] == `MCTP_CNT_MAX);

            // Buffer reload moments; timing bit only matters when buffering
            wire bfa  = mode_q[g][`MCTP_BFA_BIT];
            wire bfb  = mode_q[g][`MCTP_BFB_BIT];
            wire buffer_write_timing = mode_q[g][`MCTP_BUFFER_WRITE_TIMING_BIT];
            wire ld_a = bfa & (buffer_write_timing ? clr : m_a);
            wire ld_b = bfb & (buffer_write_timing ? clr : m_b);

            wire [4:0] set_v = {ovf, m_d, m_c, m_b, m_a};
            // Clear only where 0 is written and a 1 was read before
            wire [4:0] clr_v = sr_wr ? (~wd[4:0] & arm_q[g]) : 5'h00;
            wire       pwm   = (mode_q[g][`MCTP_MD_HI:0] == `MCTP_MD_PWM);
            wire [1:0] act   = ioc_q[g][1:0];
            wire       init  = ioc_q[g][`MCTP_IOC_INIT];

            // Configuration and general registers
            always @(posedge mclk) begin
                if (srst) begin
                    ctl_q[g]  <= `MCTP_ZERO16;
                    mode_q[g] <= `MCTP_ZERO16;
                    ioc_q[g]  <= `MCTP_ZERO16;
                    ier_q[g]  <= `MCTP_ZERO16;
                    gra_q[g]  <= `MCTP_GR_RST;
                    grb_q[g]  <= `MCTP_GR_RST;
                    grc_q[g]  <= `MCTP_GR_RST;
                    grd_q[g]  <= `MCTP_GR_RST;
                end else begin
                    // Reserved bits are masked off on every write
                    if (wsel && aoff == `MCTP_CTL_OFF)
                        ctl_q[g] <= mctp_merge(ctl_q[g], wd, ws) & `MCTP_CTL_MASK;
                    if (wsel && aoff == `MCTP_MODE_OFF)
                        mode_q[g] <= mctp_merge(mode_q[g], wd, ws) & `MCTP_MODE_MASK;
                    if (wsel && aoff == `MCTP_IOC_OFF)
                        ioc_q[g] <= mctp_merge(ioc_q[g], wd, ws) & `MCTP_IOC_MASK;
                    if (wsel && aoff == `MCTP_IER_OFF)
                        ier_q[g] <= mctp_merge(ier_q[g], wd, ws) & `MCTP_IER_MASK;
                    // A software write beats a buffer reload in the same cycle
                    if (wsel && aoff == `MCTP_GRA_OFF)
                        gra_q[g] <= mctp_merge(gra_q[g], wd, ws);
                    else if (ld_a)
                        gra_q[g] <= grc_q[g];
                    if (wsel && aoff == `MCTP_GRB_OFF)
                        grb_q[g] <= mctp_merge(grb_q[g], wd, ws);
                    else if (ld_b)
                        grb_q[g] <= grd_q[g];
                    if (wsel && aoff == `MCTP_GRC_OFF)
                        grc_q[g] <= mctp_merge(grc_q[g], wd, ws);
                    if (wsel && aoff == `MCTP_GRD_OFF)
                        grd_q[g] <= mctp_merge(grd_q[g], wd, ws);
                end
            end

            // Counter: software write wins over counting
            always @(posedge mclk) begin
                if (srst) begin
                    cnt_q[g] <= `MCTP_ZERO16;
                end else if (wsel && aoff == `MCTP_CNT_OFF) begin
                    cnt_q[g] <= mctp_merge(cnt_q[g], wd, ws);
                end else if (clr) begin
                    cnt_q[g] <= `MCTP_ZERO16;
                end else if (tick) begin
                    // Wraps from all ones to zero naturally
                    cnt_q[g] <= cnt_q[g] + 16'h0001;
                end
            end

            // Flags: a set in the clearing cycle wins
            always @(posedge mclk) begin
                if (srst) begin
                    flg_q[g] <= 5'h00;
                    arm_q[g] <= 5'h00;
                end else begin
                    flg_q[g] <= (flg_q[g] & ~clr_v) | set_v;
                    if (sr_rd)
                        arm_q[g] <= flg_q[g];
                    else if (sr_wr)
                        arm_q[g] <= 5'h00;
                end
            end

            // Output pin: initial level on config write, action on match A
            always @(posedge mclk) begin
                if (srst) begin
                    pin_q[g] <= 1'b0;
                end else if (wsel && aoff == `MCTP_IOC_OFF && ws[0]) begin
                    pin_q[g] <= wd[`MCTP_IOC_INIT];
                end else if (act == `MCTP_ACT_HOLD) begin
                    pin_q[g] <= init;
                end else if (m_a) begin
                    // Match A wins over a clear in the same tick so A equal to the clearing register gives full duty
                    case (act)
                        `MCTP_ACT_LOW:  pin_q[g] <= 1'b0;
                        `MCTP_ACT_HIGH: pin_q[g] <= 1'b1;
                        `MCTP_ACT_TGL:  pin_q[g] <= ~pin_q[g];
                        default:        pin_q[g] <= init;
                    endcase
                end else if (pwm && clr) begin
                    // Period end restores the initial level; relies on legal codes
                    pin_q[g] <= init;
                end
            end

            // Request: any flag with its enable; registered for a clean output
            always @(posedge mclk) begin
                if (srst) begin
                    irq_q[g] <= 1'b0;
                end else begin
                    irq_q[g] <= |(flg_q[g] & ier_q[g][4:0]);
                end
            end
        end
    endgenerate

endmodule

// ==== sim/mctp_monitor.sv ====
/* Port checker for the compare timer.
   Assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/10ps
module mctp_monitor (
    input wire        mclk,
    input wire        srst,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire [3:0]  channel_output_pin,
    input wire [3:0]  irq_req
);
    wire       req = wb_cyc_i && wb_stb_i;        // Live request
    wire       wr  = req && wb_we_i && wb_ack_o;  // Write lands at this edge
    reg  [3:0] run_q;                             // Shadow run bits
    reg  [4:0] ier0_q;                            // Shadow channel 0 enables
    reg        wr_q;                              // Write landed last edge
    // Readable bits per address; unmapped places read zero
    function [15:0] rmask(input [7:0] a);
        if (a == 8'h00) rmask = 16'h000F;
        else if (a < 8'h10) rmask = 16'h0000;
        else case (a[5:0])
            6'h10: rmask = 16'h00FF;
            6'h14: rmask = 16'h0077;
            6'h18: rmask = 16'h0007;
            6'h1C, 6'h20: rmask = 16'h001F;
            6'h24, 6'h28, 6'h2C, 6'h30, 6'h34: rmask = 16'hFFFF;
            default: rmask = 16'h0000;
        endcase
    endfunction
    // Shadows follow landed writes; irq lags an enable write by one edge
    always @(posedge mclk) begin
        if (srst) begin
            run_q <= 4'h0;
            ier0_q <= 5'h00;
            wr_q <= 1'b0;
        end else begin
            wr_q <= wr;
            if (wr && wb_sel_i[0] && wb_adr_i == 8'h00) run_q <= wb_dat_i[3:0];
            if (wr && wb_sel_i[0] && wb_adr_i == 8'h1C) ier0_q <= wb_dat_i[4:0];
        end
    end
    AST_ACK_NEXT: assert property (@(posedge mclk) disable iff (srst)
        req && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    AST_ACK_PULSE: assert property (@(posedge mclk) disable iff (srst)
        wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (@(posedge mclk) disable iff (srst)
        $rose(wb_ack_o) |-> $past(req)) else $error("ack without request");
    AST_DAT_HIGH: assert property (@(posedge mclk) disable iff (srst)
        wb_ack_o |-> wb_dat_o[31:16] == 16'h0000) else $error("upper data set");
    AST_RSVD_ZERO: assert property (@(posedge mclk) disable iff (srst)
        wb_ack_o && !wb_we_i |-> (wb_dat_o[15:0] & ~rmask(wb_adr_i)) == 16'h0000)
        else $error("reserved bit read one");
    AST_RESET_QUIET: assert property (@(posedge mclk)
        srst |=> !wb_ack_o && channel_output_pin == 4'h0 && irq_req == 4'h0)
        else $error("outputs live in reset");
    AST_STOP_HOLD: assert property (@(posedge mclk) disable iff (srst)
        run_q == 4'h0 && !wr && !wr_q |=> $stable(channel_output_pin) && $stable(irq_req))
        else $error("activity while stopped");
    AST_IRQ_GATE: assert property (@(posedge mclk) disable iff (srst)
        ier0_q == 5'h00 |=> !irq_req[0]) else $error("request while disabled");
endmodule
bind mctp_timer mctp_monitor u_mon (.mclk(mclk), .srst(srst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .channel_output_pin(channel_output_pin), .irq_req(irq_req));

// ==== sim/mctp_pin_load.sv ====
/* Load on the timer output pins: a receiving input stage.
   Assumes the pins are always driven by the timer. */
`timescale 1ns/10ps
module mctp_pin_load (
    input  wire       mclk,
    input  wire [3:0] channel_output_pin,
    output reg  [3:0] seen_pin_q
);
    // Latch the level each clock, as a receiver would
    always @(posedge mclk) begin
        seen_pin_q <= channel_output_pin;
    end
endmodule

// ==== sim/mctp_timer_bench.sv ====
/* Self-checking bench: Wishbone tasks, read expectation queue, pin load.
   Assumes the port checker is bound to the timer. */
`timescale 1ns/10ps
module mctp_timer_bench;
    logic        mclk = 1'b0;
    logic        srst = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    wire  [31:0] rdat;
    wire         ack;
    wire  [3:0]  pin, irq, seen;
    logic [15:0] exp_q[$];                   // Expected read data, oldest first
    logic [15:0] lfsr_q = 16'd39449;         // Random source
    logic [5:0]  offs [10] = '{6'h10, 6'h14, 6'h18, 6'h1C, 6'h20, 6'h24, 6'h28, 6'h2C,
                               6'h30, 6'h34};
    logic [15:0] bmode [4] = '{16'h0010, 16'h0040, 16'h0020, 16'h0050};
    logic [7:0]  breg [4] = '{8'hE8, 8'hE8, 8'hEC, 8'hE8};
    logic [15:0] bexp [4] = '{16'h0100, 16'h0003, 16'h0100, 16'h0003};
    logic [2:0]  code;
    logic        e;
    int          failures = 0, checks_done = 0, i, c;
    initial begin
        forever #2 mclk = ~mclk;
    end
    mctp_timer uut (.mclk(mclk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .channel_output_pin(pin), .irq_req(irq));
    mctp_pin_load u_load (.mclk(mclk), .channel_output_pin(pin), .seen_pin_q(seen));
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task check(input logic [31:0] seen_v, input logic [31:0] exp_v);
        checks_done++;
        if (seen_v !== exp_v) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
        end
    endtask
    // One classic cycle; held until ack is sampled high at a rising edge
    task bus(input logic [7:0] a, input logic w, input logic [15:0] d);
        int n;
        @(posedge mclk);
        {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'h3, 16'h0000, d};
        n = 0;
        // Ack as sampled at each rising edge; the transfer lands where it is high
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n == 50) failures++;
        {cyc, stb, we} <= 3'b000;
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        bus(a, 1'b1, d);
    endtask
    task rd(input logic [7:0] a, input logic [15:0] d);
        exp_q.push_back(d);
        bus(a, 1'b0, 16'h0000);
    endtask
    // Counter runs for exactly w + 3 edges between the two run writes
    task run_for(input logic [3:0] bits, input int w);
        wr(8'h00, {12'h000, bits});
        repeat (w) @(posedge mclk);
        wr(8'h00, 16'h0000);
    endtask
    task summarize();
        $display("checks=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Read answers are judged against the oldest note, mid-cycle
    always @(negedge mclk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            if (exp_q.size() == 0) failures++;
            else check(rdat, {16'h0000, exp_q.pop_front()});
        end
    end
    // Hang guard, well beyond the roughly 1100 cycles the tests need
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        rd(8'h00, 16'h0000);
        for (c = 0; c < 4; c++)
            for (i = 0; i < 10; i++)
                rd({c[1:0], offs[i]}, i < 6 ? 16'h0000 : 16'hFFFF);
        // Random data, reserved bits and an unmapped place
        for (i = 0; i < 8; i++) begin
            lfsr_q = nxt(lfsr_q);
            wr(8'h2C, lfsr_q);
            rd(8'h2C, lfsr_q);
            wr(8'h1C, lfsr_q);
            rd(8'h1C, lfsr_q & 16'h001F);
            wr(8'h08, lfsr_q);
            rd(8'h08, 16'h0000);
        end
        wr(8'h14, 16'hFF88);
        rd(8'h14, 16'h0000);
        wr(8'h00, 16'hFFF0);
        rd(8'h00, 16'h0000);
        // Every pin code on channel 0, match at 5, then flag clearing
        wr(8'h2C, 16'hFFFF);
        wr(8'h28, 16'h0005);
        for (i = 0; i < 8; i++) begin
            code = i[2:0];
            e = code[1:0] == 2'b11 ? ~code[2] : (code[1:0] == 2'b00 ? code[2] : code[1]);
            wr(8'h24, 16'h0000);
            wr(8'h1C, code[0] ? 16'h0001 : 16'h0002);
            wr(8'h18, {13'h0000, code});
            @(negedge mclk);
            check(32'(pin[0]), 32'(code[2]));
            run_for(4'h1, 12);
            @(negedge mclk);
            check(32'(seen[0]), 32'(e));
            check(32'(irq[0]), 32'(code[0]));
            wr(8'h20, 16'h0000);
            rd(8'h20, 16'h0001);
            wr(8'h20, 16'h001F);
            rd(8'h20, 16'h0001);
            wr(8'h20, 16'h0000);
            rd(8'h20, 16'h0000);
            @(negedge mclk);
            check(32'(irq[0]), 32'h0);
        end
        // Channel 1 wraps at full speed, then divided and refused prescale
        wr(8'h5C, 16'h0010);
        wr(8'h64, 16'hFFFE);
        run_for(4'h2, 0);
        rd(8'h64, 16'h0001);
        rd(8'h60, 16'h001F);
        check(32'(irq[1]), 32'h1);
        wr(8'h5C, 16'h0000);
        repeat (2) @(negedge mclk);
        check(32'(irq[1]), 32'h0);
        for (i = 0; i < 2; i++) begin
            wr(8'h50, i ? 16'h0004 : 16'h0003);
            wr(8'h64, 16'h0000);
            run_for(4'h2, 125);
            rd(8'h64, i ? 16'h0000 : 16'h0002);
        end
        // Channel 2 in PWM: period B = 5 by clear on B, duty A = 2, low then high
        wr(8'h94, 16'h0002);
        wr(8'h90, 16'h0040);
        wr(8'hA8, 16'h0002);
        wr(8'hAC, 16'h0005);
        wr(8'hA4, 16'h0000);
        wr(8'h98, 16'h0002);
        run_for(4'h4, 0);
        rd(8'hA4, 16'h0003);
        check(32'(pin[2]), 32'h1);
        run_for(4'h4, 0);
        rd(8'hA4, 16'h0000);
        check(32'(pin[2]), 32'h0);
        // Buffer pairs on channel 3, with and without buffering
        for (i = 0; i < 4; i++) begin
            wr(8'hD4, bmode[i]);
            wr(breg[i], 16'h0003);
            wr(breg[i] + 8'h08, 16'h0100);
            wr(8'hE4, 16'h0000);
            run_for(4'h8, 7);
            rd(breg[i], bexp[i]);
        end
        summarize();
    end
endmodule
